//--- hw/cilsd_map.svh
// Offsets, field positions, reset values and constants of the compact load/store decoder
// What this block does
// RQ1 - Halfword transfer uses base register plus 6-bit byte offset as address
// RQ2 - Halfword store writes low sixteen bits of the data register
// RQ3 - Halfword load fills low half and clears upper sixteen bits
// RQ4 - Halfword five-bit offset field counts halfwords, doubled to bytes
// RQ5 - Stack-relative access adds unsigned word offset up to 255 words to SP
// RQ6 - Stack-relative eight-bit word offset is scaled by four
// RQ7 - Load-address adds word-aligned 10-bit constant to PC or SP into destination
// RQ8 - PC source is instruction address plus four with bit 1 cleared
// RQ9 - Load-address leaves the status word flags unchanged
// RQ10 - Stack adjust adds or subtracts a word-aligned magnitude up to 508
// RQ11 - Stack adjust offset is sign plus seven-bit word magnitude times four
// RQ12 - Stack adjust changes no condition flag
// RQ13 - Push and pop use an eight-bit low register mask, full descending stack
// RQ14 - Push with extra bit also stores link register, SP drops by total size
// RQ15 - Pop loads masked registers from successive words and writes back SP
// RQ16 - Pop with extra bit also loads PC last, causing a branch
// RQ17 - Each instruction keeps the cycle count of its full-width equivalent
// RQ18 - Multi-register transfers go ascending, lowest register at lowest address
// RQ19 - Register fields are three bits, only low registers besides SP, LR, PC
// RQ20 - PC seen by instructions is four bytes ahead of the current one
`ifndef CILSD_MAP_SVH
`define CILSD_MAP_SVH
`define CILSD_OFF_INSTR 8'h00
`define CILSD_OFF_IADDR 8'h04
`define CILSD_OFF_STATUS 8'h08
`define CILSD_OFF_SP 8'h0C
`define CILSD_OFF_PSW 8'h10
`define CILSD_OFF_BRTGT 8'h14
`define CILSD_GPR_PAGE 2'h1
`define CILSD_GPR_COUNT 4'h9
`define CILSD_ST_BUSY 0
`define CILSD_ST_BRANCH 1
`define CILSD_ST_UNDEF 2
`define CILSD_OPC_HALF 4'h8
`define CILSD_OPC_SPREL 4'h9
`define CILSD_OPC_LDADDR 4'hA
`define CILSD_OPC_MISC 4'hB
`define CILSD_MISC_ADDSP 4'h0
`define CILSD_MISC_PP 2'h2
`define CILSD_BIT_L 11
`define CILSD_BIT_EXTRA 8
`define CILSD_BIT_SIGN 7
`define CILSD_LR_IDX 4'h8
`define CILSD_PC_IDX 4'hF
`define CILSD_PC_AHEAD 32'h0000_0004
`define CILSD_PC_BIT1_MASK 32'hFFFF_FFFD
`define CILSD_WORD_STEP 32'h0000_0004
`define CILSD_SP_RST 32'h0000_0000
`define CILSD_PSW_RST 32'h0000_0000
`define CILSD_IADDR_RST 32'h0000_0000
`endif

//--- hw/cilsd_pkg.sv
// Types of the compact load/store decoder
`default_nettype none
package cilsd_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_GET_BASE, ST_GET_DATA, ST_MEM, ST_NEXT} cilsd_state_type;
endpackage
`default_nettype wire

//--- hw/cilsd_regfile.sv
// Register file memory with registered read data
`default_nettype none
module cilsd_regfile #(
  parameter int WIDTH = 32,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem_ff [0:(1<<AW)-1];
  logic [WIDTH-1:0] rdata_ff;

  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem_ff[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_ff <= '0;
    end
    else
    begin
      rdata_ff <= mem_ff[raddr];
    end
  end

  assign rdata = rdata_ff;
endmodule // cilsd_regfile
`default_nettype wire

//--- hw/cilsd_core.sv
// Execution unit for halfword, stack-relative, load-address, stack adjust and push/pop instructions
//
// Implementation choices: the Avalon-MM slave port and the address map.
`include "cilsd_map.svh"
`default_nettype none
module cilsd_core
  import cilsd_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Data memory master
  output logic [31:0] dmem_addr,
  output logic [31:0] dmem_wdata,
  output logic dmem_half,
  output logic dmem_read,
  output logic dmem_write,
  input wire logic [31:0] dmem_rdata,
  input wire logic dmem_ready,
  // Architectural state
  output logic [31:0] program_status_word,
  output logic [31:0] branch_target
);
  cilsd_state_type state_ff, nxt_state;
  logic [15:0] instr_ff, nxt_instr;
  logic [31:0] iaddr_ff, nxt_iaddr;
  logic [31:0] stack_pointer_reg_ff, nxt_stack_pointer_reg;
  logic [31:0] psw_ff, nxt_psw;
  logic [31:0] brtgt_ff, nxt_brtgt;
  logic branch_ff, nxt_branch;
  logic undef_ff, nxt_undef;
  logic [31:0] addr_ff, nxt_addr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic load_ff, nxt_load;
  logic half_ff, nxt_half;
  logic multi_ff, nxt_multi;
  logic [8:0] list_ff, nxt_list;
  logic [3:0] cur_idx_ff, nxt_cur_idx;
  logic dmem_read_ff, nxt_dmem_read;
  logic dmem_write_ff, nxt_dmem_write;
  logic wait_ff, nxt_wait;
  logic [31:0] rdata_ff, nxt_rdata;
  logic pend_ff, nxt_pend;
  logic rf_we;
  logic [3:0] rf_waddr;
  logic [31:0] rf_wdata;
  logic [3:0] rf_raddr;
  logic [31:0] rf_rdata;
  logic busy;
  logic gpr_hit;
  logic [3:0] gpr_idx;
  logic blocked;
  logic commit_wr;
  logic go;

  function automatic logic [3:0] count_ones(input logic [8:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 9; i++)
    begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  function automatic logic [3:0] lowest_set(input logic [8:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 8; i >= 0; i--)
    begin
      if (v[i])
      begin
        n = 4'(i);
      end
    end
    return n;
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] words_to_bytes(input logic [7:0] w);
    return {22'h0, w, 2'b00};
  endfunction

  cilsd_regfile #(
    .WIDTH(32),
    .AW(4)
  ) u_regfile (
    .mclk(mclk),
    .rstn(rstn),
    .we(rf_we),
    .waddr(rf_waddr),
    .wdata(rf_wdata),
    .raddr(rf_raddr),
    .rdata(rf_rdata)
  );

  // Bus decode
  always_comb
  begin
    busy = (state_ff != ST_IDLE);
    gpr_hit = (avs_address[7:6] == `CILSD_GPR_PAGE) && (avs_address[5:2] < `CILSD_GPR_COUNT) &&
              (avs_address[1:0] == 2'b00);
    gpr_idx = avs_address[5:2];
    blocked = busy && (gpr_hit || (avs_write && ((avs_address == `CILSD_OFF_INSTR) ||
              (avs_address == `CILSD_OFF_SP))));
    commit_wr = avs_write && !wait_ff;
    go = commit_wr && (avs_address == `CILSD_OFF_INSTR);
  end

  // Bus answer
  always_comb
  begin
    nxt_wait = 1'b1;
    nxt_rdata = rdata_ff;
    nxt_pend = 1'b0;
    if ((avs_read || avs_write) && wait_ff && !blocked)
    begin
      if (avs_read && gpr_hit)
      begin
        if (pend_ff)
        begin
          nxt_wait = 1'b0;
          nxt_rdata = rf_rdata;
        end
        else
        begin
          nxt_pend = 1'b1;
        end
      end
      else
      begin
        nxt_wait = 1'b0;
        if (avs_read)
        begin
          if (avs_address == `CILSD_OFF_INSTR)
          begin
            nxt_rdata = {16'h0000, instr_ff};
          end
          else if (avs_address == `CILSD_OFF_IADDR)
          begin
            nxt_rdata = iaddr_ff;
          end
          else if (avs_address == `CILSD_OFF_STATUS)
          begin
            nxt_rdata = {29'h0, undef_ff, branch_ff, busy};
          end
          else if (avs_address == `CILSD_OFF_SP)
          begin
            nxt_rdata = stack_pointer_reg_ff;
          end
          else if (avs_address == `CILSD_OFF_PSW)
          begin
            nxt_rdata = psw_ff;
          end
          else if (avs_address == `CILSD_OFF_BRTGT)
          begin
            nxt_rdata = brtgt_ff;
          end
          else
          begin
            nxt_rdata = 32'h0000_0000;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      pend_ff <= 1'b0;
    end
    else
    begin
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      pend_ff <= nxt_pend;
    end
  end

  // Instruction sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_instr = instr_ff;
    nxt_iaddr = iaddr_ff;
    nxt_stack_pointer_reg = stack_pointer_reg_ff;
    nxt_psw = psw_ff;
    nxt_brtgt = brtgt_ff;
    nxt_branch = branch_ff;
    nxt_undef = undef_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_load = load_ff;
    nxt_half = half_ff;
    nxt_multi = multi_ff;
    nxt_list = list_ff;
    nxt_cur_idx = cur_idx_ff;
    nxt_dmem_read = dmem_read_ff;
    nxt_dmem_write = dmem_write_ff;
    rf_we = 1'b0;
    rf_waddr = cur_idx_ff;
    rf_wdata = 32'h0000_0000;
    rf_raddr = gpr_idx;
    // RQ9 flags untouched
    if (commit_wr && (avs_address == `CILSD_OFF_PSW))
    begin
      nxt_psw = merge_be(psw_ff, avs_writedata, avs_byteenable);
    end
    if (commit_wr && (avs_address == `CILSD_OFF_IADDR))
    begin
      nxt_iaddr = merge_be(iaddr_ff, avs_writedata, avs_byteenable);
    end
    if (commit_wr && (avs_address == `CILSD_OFF_SP))
    begin
      nxt_stack_pointer_reg = merge_be(stack_pointer_reg_ff, avs_writedata, avs_byteenable);
    end
    if (commit_wr && gpr_hit)
    begin
      rf_we = 1'b1;
      rf_waddr = gpr_idx;
      rf_wdata = avs_writedata;
    end
    // RQ17 fixed sequencing
    case (state_ff)
      ST_IDLE:
      begin
        if (go)
        begin
          nxt_instr = avs_writedata[15:0];
          nxt_branch = 1'b0;
          nxt_undef = 1'b0;
          nxt_load = avs_writedata[`CILSD_BIT_L];
          nxt_half = 1'b0;
          nxt_multi = 1'b0;
          // RQ19 three-bit fields
          nxt_cur_idx = {1'b0, avs_writedata[10:8]};
          if (avs_writedata[15:12] == `CILSD_OPC_HALF)
          begin
            nxt_half = 1'b1;
            nxt_cur_idx = {1'b0, avs_writedata[2:0]};
            rf_raddr = {1'b0, avs_writedata[5:3]};
            nxt_state = ST_GET_BASE;
          end
          else if (avs_writedata[15:12] == `CILSD_OPC_SPREL)
          begin
            // RQ5 RQ6 SP plus words
            nxt_addr = stack_pointer_reg_ff + words_to_bytes(avs_writedata[7:0]);
            if (avs_writedata[`CILSD_BIT_L])
            begin
              nxt_dmem_read = 1'b1;
              nxt_state = ST_MEM;
            end
            else
            begin
              rf_raddr = {1'b0, avs_writedata[10:8]};
              nxt_state = ST_GET_DATA;
            end
          end
          else if (avs_writedata[15:12] == `CILSD_OPC_LDADDR)
          begin
            // RQ7 RQ8 RQ20 address sum
            rf_we = 1'b1;
            rf_waddr = {1'b0, avs_writedata[10:8]};
            rf_wdata = (avs_writedata[`CILSD_BIT_L] ? stack_pointer_reg_ff :
                        ((iaddr_ff + `CILSD_PC_AHEAD) & `CILSD_PC_BIT1_MASK)) + words_to_bytes(avs_writedata[7:0]);
          end
          else if ((avs_writedata[15:12] == `CILSD_OPC_MISC) && (avs_writedata[11:8] == `CILSD_MISC_ADDSP))
          begin
            // RQ10 RQ11 RQ12 signed adjust
            if (avs_writedata[`CILSD_BIT_SIGN])
            begin
              nxt_stack_pointer_reg = stack_pointer_reg_ff - words_to_bytes({1'b0, avs_writedata[6:0]});
            end
            else
            begin
              nxt_stack_pointer_reg = stack_pointer_reg_ff + words_to_bytes({1'b0, avs_writedata[6:0]});
            end
          end
          else if ((avs_writedata[15:12] == `CILSD_OPC_MISC) && (avs_writedata[10:9] == `CILSD_MISC_PP))
          begin
            // RQ13 RQ14 RQ15 stack writeback
            nxt_multi = 1'b1;
            nxt_list = avs_writedata[8:0];
            if (avs_writedata[`CILSD_BIT_L])
            begin
              nxt_addr = stack_pointer_reg_ff;
              nxt_stack_pointer_reg = stack_pointer_reg_ff + words_to_bytes({4'h0, count_ones(avs_writedata[8:0])});
            end
            else
            begin
              nxt_addr = stack_pointer_reg_ff - words_to_bytes({4'h0, count_ones(avs_writedata[8:0])});
              nxt_stack_pointer_reg = nxt_addr;
            end
            nxt_state = ST_NEXT;
          end
          else
          begin
            nxt_undef = 1'b1;
          end
        end
      end
      ST_GET_BASE:
      begin
        // RQ1 RQ4 halfword address
        nxt_addr = rf_rdata + {26'h0, instr_ff[10:6], 1'b0};
        if (load_ff)
        begin
          nxt_dmem_read = 1'b1;
          nxt_state = ST_MEM;
        end
        else
        begin
          rf_raddr = cur_idx_ff;
          nxt_state = ST_GET_DATA;
        end
      end
      ST_GET_DATA:
      begin
        // RQ2 low half stored
        nxt_wdata = half_ff ? {16'h0000, rf_rdata[15:0]} : rf_rdata;
        nxt_dmem_write = 1'b1;
        nxt_state = ST_MEM;
      end
      ST_MEM:
      begin
        if (dmem_ready)
        begin
          nxt_dmem_read = 1'b0;
          nxt_dmem_write = 1'b0;
          if (load_ff && (cur_idx_ff == `CILSD_PC_IDX))
          begin
            // RQ16 PC popped
            nxt_brtgt = dmem_rdata;
            nxt_branch = 1'b1;
          end
          else if (load_ff)
          begin
            // RQ3 zero upper half
            rf_we = 1'b1;
            rf_wdata = half_ff ? {16'h0000, dmem_rdata[15:0]} : dmem_rdata;
          end
          if (multi_ff)
          begin
            nxt_addr = addr_ff + `CILSD_WORD_STEP;
            nxt_state = ST_NEXT;
          end
          else
          begin
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_NEXT:
      begin
        if (list_ff == 9'h000)
        begin
          nxt_state = ST_IDLE;
        end
        else
        begin
          // RQ18 ascending order
          nxt_list = list_ff & ~(9'h001 << lowest_set(list_ff));
          if (lowest_set(list_ff) == `CILSD_LR_IDX)
          begin
            nxt_cur_idx = load_ff ? `CILSD_PC_IDX : `CILSD_LR_IDX;
          end
          else
          begin
            nxt_cur_idx = lowest_set(list_ff);
          end
          if (load_ff)
          begin
            nxt_dmem_read = 1'b1;
            nxt_state = ST_MEM;
          end
          else
          begin
            rf_raddr = lowest_set(list_ff);
            nxt_state = ST_GET_DATA;
          end
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff <= ST_IDLE;
      instr_ff <= 16'h0000;
      iaddr_ff <= `CILSD_IADDR_RST;
      stack_pointer_reg_ff <= `CILSD_SP_RST;
      psw_ff <= `CILSD_PSW_RST;
      brtgt_ff <= 32'h0000_0000;
      branch_ff <= 1'b0;
      undef_ff <= 1'b0;
      addr_ff <= 32'h0000_0000;
      wdata_ff <= 32'h0000_0000;
      load_ff <= 1'b0;
      half_ff <= 1'b0;
      multi_ff <= 1'b0;
      list_ff <= 9'h000;
      cur_idx_ff <= 4'h0;
      dmem_read_ff <= 1'b0;
      dmem_write_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      instr_ff <= nxt_instr;
      iaddr_ff <= nxt_iaddr;
      stack_pointer_reg_ff <= nxt_stack_pointer_reg;
      psw_ff <= nxt_psw;
      brtgt_ff <= nxt_brtgt;
      branch_ff <= nxt_branch;
      undef_ff <= nxt_undef;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      load_ff <= nxt_load;
      half_ff <= nxt_half;
      multi_ff <= nxt_multi;
      list_ff <= nxt_list;
      cur_idx_ff <= nxt_cur_idx;
      dmem_read_ff <= nxt_dmem_read;
      dmem_write_ff <= nxt_dmem_write;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign dmem_addr = addr_ff;
  assign dmem_wdata = wdata_ff;
  assign dmem_half = half_ff;
  assign dmem_read = dmem_read_ff;
  assign dmem_write = dmem_write_ff;
  assign program_status_word = psw_ff;
  assign branch_target = brtgt_ff;
endmodule // cilsd_core
`default_nettype wire

//--- hw/README_unused.sv
// Spare source file that holds no logic
`default_nettype none
`default_nettype wire

//--- tb/cilsd_core_chk.sv
// Port assertions for the compact load/store decoder
`default_nettype none
module cilsd_core_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Data bus
  input wire logic [31:0] dmem_addr,
  input wire logic [31:0] dmem_wdata,
  input wire logic dmem_half,
  input wire logic dmem_read,
  input wire logic dmem_write,
  input wire logic [31:0] dmem_rdata,
  input wire logic dmem_ready,
  // State
  input wire logic [31:0] program_status_word,
  input wire logic [31:0] branch_target
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  wait_cause_a: assert property (!avs_waitrequest |-> (avs_read || avs_write))
    else $error("answer without a request");
  status_lat_a: assert property ($rose(avs_read) && avs_address == 8'h08 |=> !avs_waitrequest)
    else $error("status read not answered next cycle");
  rdata_hold_a: assert property ($changed(avs_readdata) |-> !avs_waitrequest && $past(avs_read))
    else $error("read data moved outside a read answer");
  load_hold_a: assert property (dmem_read && !dmem_ready |=> dmem_read && $stable(dmem_addr))
    else $error("load request dropped or moved before ready");
  store_hold_a: assert property (dmem_write && !dmem_ready |=> dmem_write && $stable(dmem_wdata))
    else $error("store request dropped or moved before ready");
  req_drop_a: assert property ((dmem_read || dmem_write) && dmem_ready |=> !dmem_read && !dmem_write)
    else $error("data request held after ready");
  half_upper_a: assert property (dmem_write && dmem_half |-> dmem_wdata[31:16] == 16'h0000)
    else $error("halfword store with upper bits set");
  psw_keep_a: assert property ($changed(program_status_word) |->
    $past(avs_write && !avs_waitrequest && avs_address == 8'h10))
    else $error("status word changed without a write");
  brtgt_cause_a: assert property ($changed(branch_target) |->
    ($past(dmem_read && dmem_ready) || $past(dmem_read && dmem_ready, 2)))
    else $error("branch target changed without a load");
endmodule // cilsd_core_chk
bind cilsd_core cilsd_core_chk i_chk (.mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dmem_addr(dmem_addr),
  .dmem_wdata(dmem_wdata), .dmem_half(dmem_half), .dmem_read(dmem_read), .dmem_write(dmem_write),
  .dmem_rdata(dmem_rdata), .dmem_ready(dmem_ready), .program_status_word(program_status_word),
  .branch_target(branch_target));
`default_nettype wire

//--- tb/cilsd_mem_model.sv
// Data memory model with selectable answer latency
`default_nettype none
module cilsd_mem_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Data bus
  input wire logic [31:0] dmem_addr,
  input wire logic [31:0] dmem_wdata,
  input wire logic dmem_half,
  input wire logic dmem_read,
  input wire logic dmem_write,
  output logic [31:0] dmem_rdata,
  output logic dmem_ready,
  // Latency select
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] word;
  int cnt;
  // Idle read data toggles so stale values never match
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      dmem_ready <= 1'b0;
      dmem_rdata <= 32'h5A5A_A5A5;
      cnt <= 0;
    end
    else
    begin
      dmem_ready <= 1'b0;
      dmem_rdata <= ~dmem_rdata;
      if ((dmem_read || dmem_write) && !dmem_ready)
      begin
        if (cnt < (slow ? 3 : 0))
          cnt <= cnt + 1;
        else
        begin
          cnt <= 0;
          dmem_ready <= 1'b1;
          word = mem.exists(dmem_addr) ? mem[dmem_addr] : ~dmem_addr;
          if (dmem_write)
            mem[dmem_addr] = dmem_half ? {16'h0000, dmem_wdata[15:0]} : dmem_wdata;
          if (dmem_read)
            dmem_rdata <= dmem_half ? {~word[15:0], word[15:0]} : word;
        end
      end
    end
  end
endmodule // cilsd_mem_model
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the compact load/store decoder
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, dmem_addr, dmem_wdata, dmem_rdata, program_status_word, branch_target;
  logic avs_waitrequest, dmem_half, dmem_read, dmem_write, dmem_ready;
  logic slow = 1'b0;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #12.5 mclk = ~mclk;
  cilsd_core i_dut (.mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dmem_addr(dmem_addr),
    .dmem_wdata(dmem_wdata), .dmem_half(dmem_half), .dmem_read(dmem_read), .dmem_write(dmem_write),
    .dmem_rdata(dmem_rdata), .dmem_ready(dmem_ready), .program_status_word(program_status_word),
    .branch_target(branch_target));
  cilsd_mem_model i_mem (.mclk(mclk), .rstn(rstn), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
    .dmem_half(dmem_half), .dmem_read(dmem_read), .dmem_write(dmem_write), .dmem_rdata(dmem_rdata),
    .dmem_ready(dmem_ready), .slow(slow));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      bad_count++;
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
      @(posedge mclk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, exp, msg);
  endtask
  task automatic exec(input logic [31:0] instr);
    logic [31:0] s;
    wr(8'h00, instr);
    do
      bus(1'b0, 8'h08, 32'h0000_0000, s);
    while (s[0] !== 1'b0);
  endtask
  task automatic t_misc;
    exec(32'h0000_0000);
    rchk(8'h08, 32'h0000_0004, "undefined flag");
    wr(8'h80, 32'h1234_5678);
    rchk(8'h80, 32'h0000_0000, "unmapped read");
    $display("test misc done");
  endtask
  task automatic t_half;
    wr(8'h44, 32'h0000_1000);
    wr(8'h58, 32'hABCD_1234);
    exec(32'h0000_87CE);
    chk(i_mem.mem[32'h0000_103E], 32'h0000_1234, "halfword store");
    exec(32'h0000_8FCC);
    rchk(8'h50, 32'h0000_1234, "halfword load");
    $display("test half done");
  endtask
  task automatic t_sprel;
    wr(8'h0C, 32'h0000_2000);
    exec(32'h0000_96FF);
    chk(i_mem.mem[32'h0000_23FC], 32'hABCD_1234, "sp store");
    exec(32'h0000_9FFF);
    rchk(8'h5C, 32'hABCD_1234, "sp load");
    $display("test sprel done");
  endtask
  task automatic t_ldaddr;
    wr(8'h10, 32'hF000_0000);
    wr(8'h04, 32'h0000_0102);
    exec(32'h0000_A28F);
    rchk(8'h48, 32'h0000_0340, "pc plus constant");
    exec(32'h0000_AEFF);
    rchk(8'h58, 32'h0000_23FC, "sp plus constant");
    rchk(8'h10, 32'hF000_0000, "flags kept");
    $display("test ldaddr done");
  endtask
  task automatic t_addsp;
    exec(32'h0000_B07F);
    rchk(8'h0C, 32'h0000_21FC, "sp up");
    exec(32'h0000_B0FF);
    rchk(8'h0C, 32'h0000_2000, "sp down");
    rchk(8'h10, 32'hF000_0000, "flags kept");
    chk(program_status_word, 32'hF000_0000, "psw port");
    avs_byteenable <= 4'h1;
    wr(8'h10, 32'h0000_00A5);
    avs_byteenable <= 4'hF;
    rchk(8'h10, 32'hF000_00A5, "psw byte lane");
    chk(program_status_word, 32'hF000_00A5, "psw port lane");
    $display("test addsp done");
  endtask
  task automatic t_pushpop;
    logic [31:0] e [4];
    e = '{32'h1111_0000, 32'h2222_0000, 32'h7777_0000, 32'hEEEE_0000};
    slow <= 1'b1;
    wr(8'h0C, 32'h0000_3000);
    wr(8'h40, e[0]);
    wr(8'h48, e[1]);
    wr(8'h5C, e[2]);
    wr(8'h60, e[3]);
    exec(32'h0000_B585);
    rchk(8'h0C, 32'h0000_2FF0, "push sp");
    for (int i = 0; i < 4; i++)
      chk(i_mem.mem[32'(32'h2FF0 + 4 * i)], e[i], "push word");
    wr(8'h40, 32'h0000_0000);
    wr(8'h48, 32'h0000_0000);
    exec(32'h0000_BD05);
    rchk(8'h40, e[0], "pop r0");
    rchk(8'h48, e[1], "pop r2");
    rchk(8'h14, e[2], "pop pc");
    chk(branch_target, e[2], "branch target port");
    rchk(8'h08, 32'h0000_0002, "branch flag");
    rchk(8'h0C, 32'h0000_2FFC, "pop pc sp");
    exec(32'h0000_BC80);
    rchk(8'h5C, e[3], "pop r7");
    rchk(8'h0C, 32'h0000_3000, "pop sp");
    rchk(8'h08, 32'h0000_0000, "branch flag cleared");
    exec(32'h0000_B402);
    rchk(8'h0C, 32'h0000_2FFC, "push sp no lr");
    chk(i_mem.mem[32'h0000_2FFC], 32'h0000_1000, "push r1 no lr");
    slow <= 1'b0;
    $display("test pushpop done");
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    t_misc;
    t_half;
    t_sprel;
    t_ldaddr;
    t_addsp;
    t_pushpop;
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
